// ### spc_pkg.sv
package spc_pkg;
   // address and instruction widths
   localparam int ADDR_W     = 24;
   localparam int INSTR_W    = 48;
   // cache geometry
   localparam int SET_BITS   = 4;
   localparam int NUM_SETS   = 16;
   localparam int WAYS       = 2;
   localparam int TAG_W      = ADDR_W - SET_BITS;
   // register map (word aligned byte addresses)
   localparam logic [7:0] SECOND_SEQUENCER_MODE_WORD_OFS  = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] PC_OFS     = 8'h08;
   localparam logic [7:0] START_OFS  = 8'h0C;
   // field positions in the second sequencer mode word
   localparam int CACHE_DISABLE_BIT_POS  = 4;
   localparam int CACHE_FREEZE_BIT_POS  = 19;
   // reset values
   localparam logic [31:0]       SECOND_SEQUENCER_MODE_WORD_RST = 32'h0000_0000;
   localparam logic [ADDR_W-1:0] START_RST = 24'h00_0000;
   // pipeline stage timing in core cycles
   localparam int EXEC_CYCLES = 1;
   // pipeline control states
   typedef enum logic [2:0] {
      SPC_RUN   = 3'b000, // sequential flow
      SPC_MISS  = 3'b001, // refetch after bus conflict miss
      SPC_BLK1  = 3'b010, // block conflict, extra cycle
      SPC_BLK2  = 3'b011, // dual block conflict, first of two extra cycles
      SPC_IDLE  = 3'b100  // waiting for interrupt
   } spc_state_t;
endpackage

// ### spc_cache.sv
`timescale 1ns/1ps
module spc_cache
   import spc_pkg::*;
#(
   parameter int SETS = 16
) (
   // clock and reset
   input  wire logic                    clk_i,
   input  wire logic                    rst_i,
   // lookup
   input  wire logic                    look_i,
   input  wire logic [spc_pkg::ADDR_W-1:0] addr_i,
   output logic                         hit_o,
   output logic [spc_pkg::INSTR_W-1:0]  data_o,
   // fill
   input  wire logic                    fill_i,
   input  wire logic [spc_pkg::ADDR_W-1:0] faddr_i,
   input  wire logic [spc_pkg::INSTR_W-1:0] fdata_i,
   // count of valid entries
   output logic [5:0]                   valid_cnt_o
);
   initial begin
      if (SETS != NUM_SETS) $error("spc_cache: only 16 sets supported");
   end
   // one entry
   typedef struct packed {
      logic                vld;
      logic [TAG_W-1:0]    tag;
      logic [INSTR_W-1:0]  ins;
   } spc_ent_t;
   // whole cache state
   typedef struct packed {
      spc_ent_t [NUM_SETS-1:0][WAYS-1:0] ent;   // 16 sets of two
      logic [NUM_SETS-1:0]               lru;
   } spc_cst_t;
   spc_cst_t st_r;
   spc_cst_t st_nxt;
   logic [SET_BITS-1:0] idx;
   logic [SET_BITS-1:0] fidx;
   logic [WAYS-1:0]     way_hit;
   logic                victim;
   assign idx  = addr_i[SET_BITS-1:0];
   assign fidx = faddr_i[SET_BITS-1:0];
   // compare both ways of the set
   genvar w;
   generate
      for (w = 0; w < WAYS; w++) begin : g_way
         assign way_hit[w] = st_r.ent[idx][w].vld &&
                             st_r.ent[idx][w].tag == addr_i[ADDR_W-1:SET_BITS];
      end
   endgenerate
   assign hit_o  = look_i && (|way_hit);
   assign data_o = way_hit[1] ? st_r.ent[idx][1].ins : st_r.ent[idx][0].ins;
   assign victim = st_r.lru[fidx];
   // next state: lru update on hit, replacement on fill
   always_comb begin
      st_nxt = st_r;
      if (hit_o) begin
         st_nxt.lru[idx] = ~way_hit[1];             // other way is lru
      end
      if (fill_i) begin
         st_nxt.ent[fidx][victim].vld = 1'b1;
         st_nxt.ent[fidx][victim].tag = faddr_i[ADDR_W-1:SET_BITS];
         st_nxt.ent[fidx][victim].ins = fdata_i;
         st_nxt.lru[fidx]             = ~victim;    // toggle
      end
   end
   // register, cleared at reset
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r <= '0;
      end else begin
         st_r <= st_nxt;
      end
   end
   // valid entry count for status
   always_comb begin
      valid_cnt_o = 6'h00;
      for (int s = 0; s < NUM_SETS; s++) begin
         for (int k = 0; k < WAYS; k++) begin
            valid_cnt_o = valid_cnt_o + {5'h00, st_r.ent[s][k].vld};
         end
      end
   end
   a_fill_valid : assert property (@(posedge clk_i) disable iff (rst_i)
      fill_i |=> st_r.ent[$past(fidx)][$past(victim)].vld)
      else $error("filled entry not valid");
   a_lru_flip : assert property (@(posedge clk_i) disable iff (rst_i)
      fill_i && !hit_o |=> st_r.lru[$past(fidx)] != $past(victim))
      else $error("lru not toggled after fill");
endmodule

// ### spc_seq.sv
`timescale 1ns/1ps
module spc_seq
   import spc_pkg::*;
#(
   parameter int ADDR_WIDTH  = 24,
   parameter int INSTR_WIDTH = 48
) (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_i,
   // wishbone slave
   input  wire logic                        wb_cyc_i,
   input  wire logic                        wb_stb_i,
   input  wire logic                        wb_we_i,
   input  wire logic [7:0]                  wb_adr_i,
   input  wire logic [3:0]                  wb_sel_i,
   input  wire logic [31:0]                 wb_dat_i,
   output logic [31:0]                      wb_dat_o,
   output logic                             wb_ack_o,
   // program memory fetch port
   output logic                             fetch_req_o,
   output logic [spc_pkg::ADDR_W-1:0]       fetch_addr_o,
   input  wire logic [spc_pkg::INSTR_W-1:0] fetch_data_i,
   // decode side feedback from execute path
   input  wire logic                        ex_pm_access_i,
   input  wire logic                        ex_blk_conf_i,
   input  wire logic                        ex_dual_blk_i,
   input  wire logic                        ex_idle_i,
   input  wire logic                        irq_i,
   // pipeline outputs
   output logic [spc_pkg::INSTR_W-1:0]      dec_instr_o,
   output logic [spc_pkg::ADDR_W-1:0]       dec_addr_o,
   output logic                             dec_valid_o,
   output logic [spc_pkg::INSTR_W-1:0]      ex_instr_o,
   output logic [spc_pkg::ADDR_W-1:0]       pc_o,
   output logic                             ex_valid_o,
   output logic                             stall_o
);
   initial begin
      if (ADDR_WIDTH != ADDR_W || INSTR_WIDTH != INSTR_W) begin
         $error("spc_seq: widths must match package");
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   ////////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      spc_state_t          fsm;      // pipeline control
      logic [ADDR_W-1:0]   fa;       // fetch address
      logic [ADDR_W-1:0]   da;       // decode address
      logic [ADDR_W-1:0]   pc;       // execute address
      logic [INSTR_W-1:0]  di;       // decode instruction
      logic [INSTR_W-1:0]  ei;       // execute instruction
      logic                dv;       // decode valid
      logic                ev;       // execute valid
      logic                cache_disable_bit;    // cache disable
      logic                cache_freeze_bit;    // cache freeze
      logic [ADDR_W-1:0]   start;    // restart address
      logic                ack;      // bus acknowledge
      logic [31:0]         rdat;     // bus read data
      logic [15:0]         misses;   // miss counter
   } spc_st_t;

   spc_st_t st_r;                    // registered state
   spc_st_t st_nxt;                  // next state

   // cache hookup
   logic                 c_look;     // lookup strobe
   logic                 c_hit;      // lookup hit
   logic [INSTR_W-1:0]   c_data;     // hit instruction
   logic                 c_fill;     // fill strobe
   logic [5:0]           c_cnt;      // valid entries
   logic                 bus_conf;   // pm bus conflict this cycle
   logic                 wb_req;     // bus request
   logic [31:0]          mode_word;  // assembled mode word
   logic [31:0]          wmask;      // byte-lane mask

   ////////////////////////////////////////////////////////////////////////////
   // cache
   ////////////////////////////////////////////////////////////////////////////

   // conflict only while running, with a valid executing instruction
   assign bus_conf = (st_r.fsm == SPC_RUN) && st_r.ev && ex_pm_access_i;
   // disabled cache does no lookup, so never supplies
   assign c_look   = bus_conf && !st_r.cache_disable_bit;
   // fill on refetch after a bus miss, when enabled and unfrozen
   assign c_fill   = (st_r.fsm == SPC_MISS) && !st_r.cache_disable_bit && !st_r.cache_freeze_bit;

   spc_cache #(
      .SETS (NUM_SETS)
   ) u_cache (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .look_i      (c_look),
      .addr_i      (st_r.fa),        // displaced n+2 fetch address
      .hit_o       (c_hit),
      .data_o      (c_data),
      .fill_i      (c_fill),
      .faddr_i     (st_r.fa),
      .fdata_i     (fetch_data_i),
      .valid_cnt_o (c_cnt)
   );

   ////////////////////////////////////////////////////////////////////////////
   // bus slave helpers
   ////////////////////////////////////////////////////////////////////////////

   assign wb_req = wb_cyc_i && wb_stb_i && !st_r.ack;

   // byte enables to bit mask
   genvar b;
   generate
      for (b = 0; b < 4; b++) begin : g_sel
         assign wmask[8*b+7:8*b] = {8{wb_sel_i[b]}};
      end
   endgenerate

   // mode word view with only the two live bits
   always_comb begin
      mode_word            = SECOND_SEQUENCER_MODE_WORD_RST;
      mode_word[CACHE_DISABLE_BIT_POS] = st_r.cache_disable_bit;
      mode_word[CACHE_FREEZE_BIT_POS] = st_r.cache_freeze_bit;
   end

   ////////////////////////////////////////////////////////////////////////////
   // next state
   ////////////////////////////////////////////////////////////////////////////

   always_comb begin
      st_nxt      = st_r;
      st_nxt.ack  = wb_req;
      st_nxt.rdat = 32'h0000_0000;
      // register reads
      if (wb_req && !wb_we_i) begin
         unique case (wb_adr_i)
            SECOND_SEQUENCER_MODE_WORD_OFS:  st_nxt.rdat = mode_word;
            STATUS_OFS: st_nxt.rdat = {8'h00, st_r.misses, 2'b00, c_cnt};
            PC_OFS:     st_nxt.rdat = {8'h00, st_r.pc};
            START_OFS:  st_nxt.rdat = {8'h00, st_r.start};
            default:    st_nxt.rdat = 32'h0000_0000; // unmapped reads zero
         endcase
      end
      // register writes
      if (wb_req && wb_we_i) begin
         if (wb_adr_i == SECOND_SEQUENCER_MODE_WORD_OFS) begin
            if (wb_sel_i[0]) begin
               st_nxt.cache_disable_bit = wb_dat_i[CACHE_DISABLE_BIT_POS];
            end
            if (wb_sel_i[2]) begin
               st_nxt.cache_freeze_bit = wb_dat_i[CACHE_FREEZE_BIT_POS];
            end
         end else if (wb_adr_i == START_OFS) begin
            st_nxt.start = (st_r.start & ~wmask[23:0]) | (wb_dat_i[23:0] & wmask[23:0]);
         end
      end
      // pipeline
      unique case (st_r.fsm)
         SPC_RUN: begin
            if (st_r.ev && ex_idle_i && !irq_i) begin
               st_nxt.fsm = SPC_IDLE;
            end else if (st_r.ev && ex_blk_conf_i) begin
               st_nxt.fsm = ex_dual_blk_i ? SPC_BLK2 : SPC_BLK1;
            end else if (bus_conf && !c_hit) begin
               st_nxt.fsm = SPC_MISS;
               st_nxt.ev  = 1'b0;                     // bubble into execute
               st_nxt.pc  = st_r.da;
               st_nxt.ei  = st_r.di;
               st_nxt.misses = st_r.misses + 16'h0001;
            end else begin
               // advance one per clock, fetch n+2
               st_nxt.pc = st_r.da;
               st_nxt.ei = st_r.di;
               st_nxt.ev = st_r.dv;
               st_nxt.da = st_r.fa;
               st_nxt.di = c_hit ? c_data : fetch_data_i;
               st_nxt.dv = 1'b1;
               st_nxt.fa = st_r.fa + 24'h00_0001;
            end
         end
         SPC_MISS: begin
            // decode holds; executing slot was emptied; now fetch from memory
            st_nxt.fsm = SPC_RUN;
            st_nxt.ev  = 1'b1;
            st_nxt.pc  = st_r.pc;
            st_nxt.da  = st_r.fa;
            st_nxt.di  = fetch_data_i;
            st_nxt.dv  = 1'b1;
            st_nxt.fa  = st_r.fa + 24'h00_0001;
            st_nxt.ev  = st_r.dv;
            st_nxt.ei  = st_r.ei;
         end
         SPC_BLK1: begin
            // last cycle of the conflicting instruction: the fetch of n+2
            // lands now, so n+1 executes next with no extra bubble
            st_nxt.fsm = SPC_RUN;                     // instruction in its last cycle
            st_nxt.pc  = st_r.da;
            st_nxt.ei  = st_r.di;
            st_nxt.ev  = st_r.dv;
            st_nxt.da  = st_r.fa;
            st_nxt.di  = fetch_data_i;
            st_nxt.dv  = 1'b1;
            st_nxt.fa  = st_r.fa + 24'h00_0001;
         end
         SPC_BLK2: begin
            st_nxt.fsm = SPC_BLK1;
         end
         SPC_IDLE: begin
            if (irq_i) begin
               st_nxt.fsm = SPC_RUN;
            end
         end
         default: st_nxt.fsm = SPC_RUN;
      endcase
      // start word write in plain flow restarts the fetch at that address
      // and flushes decode and execute, like a jump; while a stall runs
      // the word is only stored, so a stall sequence is never cut short
      if (wb_req && wb_we_i && (wb_adr_i == START_OFS) &&
          (st_r.fsm == SPC_RUN) && (st_nxt.fsm == SPC_RUN)) begin
         st_nxt.fa = st_nxt.start;
         st_nxt.dv = 1'b0;                            // flushed decode slot
         st_nxt.ev = 1'b0;                            // flushed execute slot
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   ////////////////////////////////////////////////////////////////////////////

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         st_r       <= '0;
         st_r.fsm   <= SPC_RUN;
         st_r.cache_disable_bit <= SECOND_SEQUENCER_MODE_WORD_RST[CACHE_DISABLE_BIT_POS];
         st_r.cache_freeze_bit <= SECOND_SEQUENCER_MODE_WORD_RST[CACHE_FREEZE_BIT_POS];
         st_r.fa    <= START_RST;
         st_r.start <= START_RST;
      end else begin
         st_r <= st_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   ////////////////////////////////////////////////////////////////////////////

   // fetch from memory while running with no cache hit and no bus conflict, and in the miss refetch; not in BLK2 or idle
   // the last cycle of a block conflict (BLK1) also fetches n+2 from memory
   assign fetch_req_o  = ((st_r.fsm == SPC_RUN) && !c_hit && !bus_conf) ||
                         (st_r.fsm == SPC_MISS) ||
                         (st_r.fsm == SPC_BLK1);
   assign fetch_addr_o = st_r.fa;
   assign dec_instr_o  = st_r.di;
   assign dec_addr_o   = st_r.da;
   assign dec_valid_o  = st_r.dv;
   assign ex_instr_o   = st_r.ei;
   assign pc_o         = st_r.pc;
   assign ex_valid_o   = st_r.ev && (st_r.fsm != SPC_IDLE);
   assign stall_o      = (st_r.fsm != SPC_RUN);
   assign wb_ack_o     = st_r.ack;
   assign wb_dat_o     = st_r.rdat;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   ////////////////////////////////////////////////////////////////////////////

   a_fa_ahead : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.fsm == SPC_RUN && st_r.ev && st_r.dv && !bus_conf |-> st_r.fa == st_r.pc + 24'h2)
      else $error("fetch not two ahead of pc");
   a_miss_stall : assert property (@(posedge clk_i) disable iff (rst_i)
      bus_conf && !c_hit && !ex_blk_conf_i && !ex_idle_i |=> st_r.fsm == SPC_MISS ##1 st_r.fsm == SPC_RUN)
      else $error("miss not one stall cycle");
   a_hit_nostall : assert property (@(posedge clk_i) disable iff (rst_i)
      c_hit && !ex_blk_conf_i && !ex_idle_i |=> st_r.fsm == SPC_RUN && st_r.di == $past(c_data))
      else $error("hit stalled or wrong data");
   // a refetch while disabled or frozen must leave the entry count alone
   a_fill_gate : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.fsm == SPC_MISS && (st_r.cache_disable_bit || st_r.cache_freeze_bit) |=> c_cnt == $past(c_cnt))
      else $error("cache loaded while disabled or frozen");
   // a disabled cache never supplies, so every bus conflict delays the fetch
   a_dis_nohit : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.cache_disable_bit && bus_conf && !ex_blk_conf_i && !ex_idle_i |=> st_r.fsm == SPC_MISS)
      else $error("disabled cache did not delay fetch");
   a_blk_two : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.fsm == SPC_RUN && st_r.ev && ex_blk_conf_i && !ex_dual_blk_i && !ex_idle_i
      |=> st_r.fsm == SPC_BLK1 && !c_fill ##1 st_r.fsm == SPC_RUN)
      else $error("block conflict not two cycles");
   a_blk_three : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.fsm == SPC_RUN && st_r.ev && ex_blk_conf_i && ex_dual_blk_i && !ex_idle_i
      |=> st_r.fsm == SPC_BLK2 ##1 st_r.fsm == SPC_BLK1 ##1 st_r.fsm == SPC_RUN)
      else $error("dual block conflict not three cycles");
   a_idle_hold : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.fsm == SPC_IDLE && !irq_i |=> st_r.fsm == SPC_IDLE && $stable(st_r.pc))
      else $error("idle did not hold");
   a_fill_addr : assert property (@(posedge clk_i) disable iff (rst_i)
      bus_conf && !c_hit && !st_r.cache_disable_bit && !st_r.cache_freeze_bit && !ex_blk_conf_i && !ex_idle_i
      |=> c_fill && st_r.fa == $past(st_r.fa))
      else $error("fill not of displaced fetch");
   // an executing instruction leaves execute after one cycle in plain flow
   a_exec_one : assert property (@(posedge clk_i) disable iff (rst_i)
      st_r.fsm == SPC_RUN && st_r.ev && st_r.dv && !bus_conf && !ex_blk_conf_i && !ex_idle_i
      |=> st_r.pc != $past(st_r.pc))
      else $error("execute held more than one cycle");
   // a restart in plain flow loads the fetch address and empties decode
   a_restart_load : assert property (@(posedge clk_i) disable iff (rst_i)
      wb_req && wb_we_i && wb_adr_i == START_OFS && st_r.fsm == SPC_RUN && !bus_conf &&
      !ex_blk_conf_i && !ex_idle_i |=> st_r.fa == st_r.start && !st_r.dv)
      else $error("restart did not load fetch address");
   c_hit_seen  : cover property (@(posedge clk_i) c_hit);
   c_miss_seen : cover property (@(posedge clk_i) c_fill);
   c_blk_seen  : cover property (@(posedge clk_i) st_r.fsm == SPC_BLK2);
   c_blk1_seen : cover property (@(posedge clk_i) st_r.fsm == SPC_BLK1 ##1 st_r.ev);
   c_idle_seen : cover property (@(posedge clk_i) st_r.fsm == SPC_IDLE ##1 st_r.fsm == SPC_RUN);
endmodule

// ### spc_pmem_model.sv
`timescale 1ns/1ps
module spc_pmem_model (
   // clock
   input  wire logic                        clk_i,
   // fetch request from the sequencer
   input  wire logic                        fetch_req_i,
   input  wire logic [spc_pkg::ADDR_W-1:0]  addr_i,
   // instruction word back to the sequencer
   output logic [spc_pkg::INSTR_W-1:0]      data_o
);
   import spc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic [INSTR_W-1:0] last_r;                // last word really returned

   // combinational memory, word derived from its own address
   // released bus shows the inverse of the last word, so a stale sample is wrong
   always_comb begin
      if (fetch_req_i) begin
         data_o = {~addr_i, addr_i};
      end else begin
         data_o = ~last_r;
      end
   end

   // remember what was last handed over
   always_ff @(posedge clk_i) begin
      if (fetch_req_i) begin
         last_r <= data_o;
      end
   end
endmodule

// ### test_sequencer_pipeline_conflict_cache.sv
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; $display("mismatch t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module test_sequencer_pipeline_conflict_cache;
   import spc_pkg::*;
   ////////////////////////////////////////////////////////////////////////////////
   logic clk_i, rst_i, wb_cyc, wb_stb, wb_we, wb_ack, fetch_req;
   logic [7:0] wb_adr;
   logic [3:0] wb_sel;
   logic [31:0] wb_dat_w, wb_dat_r, rd;
   logic [ADDR_W-1:0] fetch_addr, dec_addr, pc;
   logic [INSTR_W-1:0] fetch_data, dec_instr, ex_instr;
   logic pm_acc, blk, dual, idle, irq, dec_valid, ex_valid, stall;
   int mismatches, tests_run, cycles;

   // core clock, 100 ns period
   initial begin
      clk_i = 1'b0;
      forever #50 clk_i = ~clk_i;
   end

   spc_seq u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat_w),
      .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack), .fetch_req_o(fetch_req),
      .fetch_addr_o(fetch_addr), .fetch_data_i(fetch_data), .ex_pm_access_i(pm_acc),
      .ex_blk_conf_i(blk), .ex_dual_blk_i(dual), .ex_idle_i(idle), .irq_i(irq),
      .dec_instr_o(dec_instr), .dec_addr_o(dec_addr), .dec_valid_o(dec_valid),
      .ex_instr_o(ex_instr), .pc_o(pc), .ex_valid_o(ex_valid), .stall_o(stall));

   spc_pmem_model u_pmem (.clk_i(clk_i), .fetch_req_i(fetch_req), .addr_i(fetch_addr),
      .data_o(fetch_data));

   ////////////////////////////////////////////////////////////////////////////////
   // verdict and end of run
   task automatic complete_run();
      if (mismatches == 0 && tests_run > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end

   // one classic wishbone cycle, waits for ack without assuming latency
   task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [3:0] sel,
                           input logic [31:0] dat, output logic [31:0] data);
      int n;
      @(posedge clk_i);
      wb_cyc <= 1'b1; wb_stb <= 1'b1; wb_we <= we;
      wb_adr <= adr; wb_sel <= sel; wb_dat_w <= dat;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack !== 1'b1 && n < 50);
      data = wb_dat_r;
      if (n >= 50) mismatches++;
      wb_cyc <= 1'b0; wb_stb <= 1'b0; wb_we <= 1'b0;
   endtask

   // steady flow: execute n, decode n+1, fetch n+2, memory word matches
   task automatic check_stream();
      repeat (3) begin
         @(posedge clk_i);
         #1;
         `CHK(ex_instr, {~pc, pc})
         `CHK(dec_addr, pc + 24'h1)
         `CHK(fetch_addr, pc + 24'h2)
         `CHK({ex_valid, stall}, 2'b10)
      end
   endtask

   // one conflicting instruction, counts stall cycles and new cache entries
   task automatic conflict(input logic p, b, d, input int exp_stall, input int exp_fill);
      logic [31:0] v0;
      int cnt;
      wb_cycle(1'b0, STATUS_OFS, 4'hF, 32'h0, v0);
      @(posedge clk_i);
      pm_acc <= p; blk <= b; dual <= d;
      @(posedge clk_i);
      pm_acc <= 1'b0; blk <= 1'b0; dual <= 1'b0;
      cnt = 0;
      repeat (6) begin
         #1;
         if (stall === 1'b1) cnt++;
         @(posedge clk_i);
      end
      `CHK(cnt, exp_stall)
      wb_cycle(1'b0, STATUS_OFS, 4'hF, 32'h0, rd);
      `CHK(rd[5:0], v0[5:0] + 6'(exp_fill))
      check_stream();
   endtask

   // idle holds the core until an interrupt, then flow resumes
   task automatic idle_wait();
      logic [ADDR_W-1:0] p;
      @(posedge clk_i);
      idle <= 1'b1;
      @(posedge clk_i);
      idle <= 1'b0;
      @(posedge clk_i);
      #1;
      p = pc;
      repeat (8) begin
         @(posedge clk_i);
         #1;
         `CHK({stall, pc}, {1'b1, p})
      end
      @(posedge clk_i);
      irq <= 1'b1;
      @(posedge clk_i);
      irq <= 1'b0;
      repeat (4) @(posedge clk_i);
      check_stream();
   endtask

   // restart at one address twice: the displaced fetch misses and fills,
   // then the same conflict hits and supplies the word without a stall
   task automatic hit_repeat();
      logic [31:0] v0;
      int cnt;
      for (int pass = 0; pass < 2; pass++) begin
         wb_cycle(1'b0, STATUS_OFS, 4'hF, 32'h0, v0);
         wb_cycle(1'b1, START_OFS, 4'hF, 32'h0000_1000, rd);
         cnt = 0;
         do begin
            @(posedge clk_i);
            #1;
            cnt++;
         end while (pc !== 24'h00_1000 && cnt < 8);
         `CHK(pc, 24'h00_1000)
         @(posedge clk_i);
         pm_acc <= 1'b1;
         @(posedge clk_i);
         pm_acc <= 1'b0;
         cnt = 0;
         repeat (4) begin
            #1;
            if (stall === 1'b1) cnt++;
            `CHK(ex_instr, {~pc, pc})
            @(posedge clk_i);
         end
         `CHK(cnt, 1 - pass)
         wb_cycle(1'b0, STATUS_OFS, 4'hF, 32'h0, rd);
         `CHK(rd[5:0], v0[5:0] + 6'(1 - pass))
      end
   endtask

   // fill every set: varied spacing spreads the displaced fetches over all sets
   task automatic fill_all();
      for (int i = 0; i < 48; i++) begin
         @(posedge clk_i);
         pm_acc <= 1'b1;
         @(posedge clk_i);
         pm_acc <= 1'b0;
         repeat (3 + i % 3) @(posedge clk_i);
      end
      repeat (4) @(posedge clk_i);
      wb_cycle(1'b0, STATUS_OFS, 4'hF, 32'h0, rd);
      `CHK(rd[5:0], 6'd32)
      check_stream();
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      rst_i = 1'b1; wb_cyc = 1'b0; wb_stb = 1'b0; wb_we = 1'b0; wb_adr = 8'h00;
      wb_sel = 4'h0; wb_dat_w = 32'h0; pm_acc = 1'b0; blk = 1'b0; dual = 1'b0;
      idle = 1'b0; irq = 1'b0; mismatches = 0; tests_run = 0; cycles = 0;
      repeat (8) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      `CHK({dec_valid, ex_valid}, 2'b00)
      for (int n = 0; n < 5 && ex_valid !== 1'b1; n++) begin
         @(posedge clk_i);
         #1;
      end
      `CHK(pc, 24'h00_0000)
      check_stream();
      // mode word and status come up cleared, sel gates the lanes
      wb_cycle(1'b0, SECOND_SEQUENCER_MODE_WORD_OFS, 4'hF, 32'h0, rd);
      `CHK(rd, 32'h0000_0000)
      wb_cycle(1'b0, STATUS_OFS, 4'hF, 32'h0, rd);
      `CHK(rd[5:0], 6'h00)
      wb_cycle(1'b1, SECOND_SEQUENCER_MODE_WORD_OFS, 4'h0, 32'h0008_0010, rd);
      wb_cycle(1'b0, SECOND_SEQUENCER_MODE_WORD_OFS, 4'hF, 32'h0, rd);
      `CHK(rd, 32'h0000_0000)
      wb_cycle(1'b0, 8'h40, 4'hF, 32'h0, rd);
      `CHK(rd, 32'h0000_0000)
      // bus conflict miss with cache enabled fills one entry
      conflict(1'b1, 1'b0, 1'b0, 1, 1);
      // frozen cache stalls but stores nothing
      wb_cycle(1'b1, SECOND_SEQUENCER_MODE_WORD_OFS, 4'hF, 32'h0008_0000, rd);
      conflict(1'b1, 1'b0, 1'b0, 1, 0);
      // disabled cache delays the fetch and stores nothing
      wb_cycle(1'b1, SECOND_SEQUENCER_MODE_WORD_OFS, 4'hF, 32'h0000_0010, rd);
      wb_cycle(1'b0, SECOND_SEQUENCER_MODE_WORD_OFS, 4'hF, 32'h0, rd);
      `CHK(rd, 32'h0000_0010)
      conflict(1'b1, 1'b0, 1'b0, 1, 0);
      wb_cycle(1'b1, SECOND_SEQUENCER_MODE_WORD_OFS, 4'hF, 32'h0, rd);
      // block conflicts take extra cycles and are never cached
      conflict(1'b0, 1'b1, 1'b0, 1, 0);
      conflict(1'b0, 1'b1, 1'b1, 2, 0);
      conflict(1'b1, 1'b1, 1'b0, 1, 0);
      hit_repeat();
      idle_wait();
      fill_all();
      complete_run();
   end
endmodule
